// file: rtl/swd_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time, 8-bit registers
`timescale 1ns/1ps
module swd_axil_slave #(
	parameter int ADDR_W = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [7:0] wr_data,
	input wire logic wr_hit,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_hit
);
	if (ADDR_W < 10) begin : g_bad
		$error("swd_axil_slave: address must be at least 10 bits");
	end

	logic aw_got_q, w_got_q, lane_q, bvalid_q, rvalid_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire wr_go = aw_got_q && w_got_q;

	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready = !w_got_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	// Only byte lane 0 carries register data
	assign wr_en = wr_go && lane_q;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign rd_addr = s_axi_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			lane_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end else begin
			if (aw_take) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_got_q <= 1'b0;
			end
			if (w_take) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				lane_q <= s_axi_wstrb[0];
			end else if (wr_go) begin
				w_got_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? swd_pkg::RESP_OKAY : swd_pkg::RESP_DECERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h00000000;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_hit ? swd_pkg::RESP_OKAY : swd_pkg::RESP_DECERR;
			rdata_q <= {24'h000000, rd_data};
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule

// file: rtl/swd_pkg.sv
// Constants for the software watchdog and interrupt enable block
package swd_pkg;
	localparam int ADDR_W = 10;
	localparam int BASE_DIV = 24;
	localparam int EXTRA_DIV = 16;
	localparam int FLAG_CYCLES = 12;
	localparam logic [7:0] IDX_RELOAD = 8'h86;
	localparam logic [7:0] IDX_IRQ_ENABLE_MAIN = 8'hA8;
	localparam logic [7:0] IDX_IP0 = 8'hA9;
	localparam logic [7:0] IDX_IRQ_ENABLE_EXTENDED = 8'hB8;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD = {IDX_RELOAD, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_MAIN = {IDX_IRQ_ENABLE_MAIN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IP0 = {IDX_IP0, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_EXTENDED = {IDX_IRQ_ENABLE_EXTENDED, 2'h0};
	localparam logic [7:0] RST_RELOAD = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE_MAIN = 8'h00;
	localparam logic [7:0] RST_IP0 = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE_EXTENDED = 8'h00;
	localparam logic [7:0] MASK_IRQ_ENABLE_MAIN = 8'h9F;
	localparam logic [7:0] MASK_IRQ_ENABLE_EXTENDED = 8'h3E;
	localparam logic [7:0] MASK_IP0 = 8'h3F;
	localparam int BIT_GLOBAL = 7;
	localparam int BIT_ARM = 6;
	localparam int BIT_SERIAL0 = 4;
	localparam int BIT_TIMER1 = 3;
	localparam int BIT_EXT1 = 2;
	localparam int BIT_TIMER0 = 1;
	localparam int BIT_EXT0 = 0;
	localparam int BIT_START = 6;
	localparam int BIT_STATUS = 6;
	localparam int BIT_PRESCALE = 7;
	localparam logic [15:0] EXPIRE_VALUE = 16'h7CFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: rtl/swd_prescaler.sv
// Watchdog count prescaler: base divider with optional extra stage
`timescale 1ns/1ps
module swd_prescaler #(
	parameter int BASE_DIV = 24,
	parameter int EXTRA_DIV = 16
) (
	input wire logic aclk,
	input wire logic clear,
	input wire logic run,
	input wire logic extra_sel,
	output logic tick
);
	localparam int BW = $clog2(BASE_DIV);
	localparam int EW = $clog2(EXTRA_DIV);

	if (BASE_DIV < 2 || EXTRA_DIV < 2) begin : g_bad
		$error("swd_prescaler: dividers must be at least 2");
	end

	logic [BW-1:0] base_q;
	logic [EW-1:0] extra_q;
	logic [9:0] gap_q;
	logic seen_q;
	wire base_end = base_q == BW'(BASE_DIV - 1);
	wire extra_end = extra_q == EW'(EXTRA_DIV - 1);

	assign tick = run && base_end && (!extra_sel || extra_end);

	always_ff @(posedge aclk) begin
		if (clear || !run) begin
			base_q <= '0;
			extra_q <= '0;
		end else begin
			base_q <= base_end ? '0 : base_q + 1'b1;
			if (base_end) begin
				extra_q <= extra_end ? '0 : extra_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gap between ticks, seen only by the check below
	always_ff @(posedge aclk) begin
		if (clear || !run) begin
			gap_q <= '0;
			seen_q <= 1'b0;
		end else if (tick) begin
			gap_q <= '0;
			seen_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 1'b1;
		end
	end

	chk_base_tick_gap: assert property (
		@(posedge aclk) disable iff (clear)
		(tick && seen_q && !extra_sel) |-> gap_q == 10'(BASE_DIV - 1))
		else $error("watchdog tick gap differs from base divider");
endmodule

// file: rtl/swd_top.sv
// Software watchdog with interrupt enable registers, AXI4-Lite register access
`timescale 1ns/1ps
module swd_top #(
	parameter int BASE_DIV = swd_pkg::BASE_DIV,
	parameter int EXTRA_DIV = swd_pkg::EXTRA_DIV,
	parameter int FLAG_CYCLES = swd_pkg::FLAG_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [swd_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [swd_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial0_irq_req,
	input wire logic timer0_ovf_req,
	input wire logic timer1_ovf_req,
	input wire logic [6:0] ext_irq_req,
	output logic serial0_irq,
	output logic timer0_ovf_irq,
	output logic timer1_ovf_irq,
	output logic [6:0] ext_irq,
	output logic wd_running,
	output logic wd_reset_req
);
	localparam logic [3:0] AGE_LAST = 4'(FLAG_CYCLES - 1);

	if (FLAG_CYCLES < 2 || FLAG_CYCLES > 16) begin : g_bad
		$error("swd_top: flag lifetime must be 2 to 16 cycles");
	end

	////////////////////////////////////////////////////////////////////////
	// Bus front end and address decode
	logic wr_en;
	logic [swd_pkg::ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic [swd_pkg::ADDR_W-1:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_hit, rd_hit;

	swd_axil_slave #(
		.ADDR_W(swd_pkg::ADDR_W)
	) u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_hit(wr_hit),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	wire wsel_reload = wr_addr == swd_pkg::ADDR_RELOAD;
	wire wsel_irq_enable_main = wr_addr == swd_pkg::ADDR_IRQ_ENABLE_MAIN;
	wire wsel_ip0 = wr_addr == swd_pkg::ADDR_IP0;
	wire wsel_irq_enable_extended = wr_addr == swd_pkg::ADDR_IRQ_ENABLE_EXTENDED;
	wire rsel_reload = rd_addr == swd_pkg::ADDR_RELOAD;
	wire rsel_irq_enable_main = rd_addr == swd_pkg::ADDR_IRQ_ENABLE_MAIN;
	wire rsel_ip0 = rd_addr == swd_pkg::ADDR_IP0;
	wire rsel_irq_enable_extended = rd_addr == swd_pkg::ADDR_IRQ_ENABLE_EXTENDED;
	assign wr_hit = wsel_reload || wsel_irq_enable_main || wsel_ip0 || wsel_irq_enable_extended;
	assign rd_hit = rsel_reload || rsel_irq_enable_main || rsel_ip0 || rsel_irq_enable_extended;
	wire wr_reload = wr_en && wsel_reload;
	wire wr_irq_enable_main = wr_en && wsel_irq_enable_main;
	wire wr_ip0 = wr_en && wsel_ip0;
	wire wr_irq_enable_extended = wr_en && wsel_irq_enable_extended;

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] reload_q, irq_enable_main_q, irq_enable_extended_q, ip0_q;
	logic status_q, running_q, wd_reset_q;
	logic [15:0] cnt_q;
	logic flag_q [2];
	logic [3:0] age_q [2];
	logic tick;

	// Expiry resets everything here except the status flag, the reset request flop and the bus front end
	wire expire = running_q && cnt_q == swd_pkg::EXPIRE_VALUE;
	wire soft_rst = !aresetn || expire;
	wire arm_q = flag_q[0];
	wire start_q = flag_q[1];
	wire arm_set = wr_irq_enable_main && wr_data[swd_pkg::BIT_ARM];
	wire start_set = wr_irq_enable_extended && wr_data[swd_pkg::BIT_START];
	wire refresh = start_set && arm_q;
	wire reload_val = 1'b0;
	wire [1:0] flag_set = {start_set, arm_set};
	wire [1:0] flag_kill = {1'b0, refresh};

	assign rd_data = rsel_reload ? reload_q :
		rsel_irq_enable_main ? (irq_enable_main_q | {1'b0, arm_q, 6'h00}) :
		rsel_ip0 ? (ip0_q | {1'b0, status_q, 6'h00}) :
		rsel_irq_enable_extended ? (irq_enable_extended_q | {1'b0, start_q, 6'h00}) : 8'h00;

	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			reload_q <= swd_pkg::RST_RELOAD;
			irq_enable_main_q <= swd_pkg::RST_IRQ_ENABLE_MAIN;
			irq_enable_extended_q <= swd_pkg::RST_IRQ_ENABLE_EXTENDED;
			ip0_q <= swd_pkg::RST_IP0;
		end else begin
			if (wr_reload) begin
				reload_q <= wr_data;
			end
			if (wr_irq_enable_main) begin
				irq_enable_main_q <= wr_data & swd_pkg::MASK_IRQ_ENABLE_MAIN;
			end
			if (wr_irq_enable_extended) begin
				irq_enable_extended_q <= wr_data & swd_pkg::MASK_IRQ_ENABLE_EXTENDED;
			end
			if (wr_ip0) begin
				ip0_q <= wr_data & swd_pkg::MASK_IP0;
			end
		end
	end

	// Status sees only the external reset, so it outlives its own reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= 1'b0;
			wd_reset_q <= 1'b0;
		end else begin
			wd_reset_q <= expire;
			if (expire) begin
				status_q <= 1'b1;
			end else if (wr_ip0 && !wr_data[swd_pkg::BIT_STATUS]) begin
				status_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Self-clearing arm and start flags; a new set restarts the lifetime
	for (genvar f = 0; f < 2; f++) begin : g_flag
		always_ff @(posedge aclk) begin
			if (soft_rst) begin
				flag_q[f] <= 1'b0;
				age_q[f] <= 4'h0;
			end else if (flag_set[f]) begin
				flag_q[f] <= 1'b1;
				age_q[f] <= 4'h0;
			end else if (flag_q[f] && (age_q[f] == AGE_LAST || flag_kill[f])) begin
				flag_q[f] <= 1'b0;
				age_q[f] <= 4'h0;
			end else if (flag_q[f]) begin
				age_q[f] <= age_q[f] + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog counter
	swd_prescaler #(
		.BASE_DIV(BASE_DIV),
		.EXTRA_DIV(EXTRA_DIV)
	) u_presc (
		.aclk(aclk),
		.clear(soft_rst || refresh),
		.run(running_q),
		.extra_sel(reload_q[swd_pkg::BIT_PRESCALE]),
		.tick(tick)
	);

	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			running_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else begin
			if (start_set) begin
				running_q <= 1'b1;
			end
			if (refresh) begin
				cnt_q <= {reload_val, reload_q[6:0], 8'h00};
			end else if (tick) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	assign wd_running = running_q;
	assign wd_reset_req = wd_reset_q;

	////////////////////////////////////////////////////////////////////////
	// Interrupt request gating
	wire global_en = irq_enable_main_q[swd_pkg::BIT_GLOBAL];
	wire [6:0] ext_en = {irq_enable_extended_q[5:1], irq_enable_main_q[swd_pkg::BIT_EXT1], irq_enable_main_q[swd_pkg::BIT_EXT0]};

	assign serial0_irq = serial0_irq_req && global_en && irq_enable_main_q[swd_pkg::BIT_SERIAL0];
	assign timer0_ovf_irq = timer0_ovf_req && global_en && irq_enable_main_q[swd_pkg::BIT_TIMER0];
	assign timer1_ovf_irq = timer1_ovf_req && global_en && irq_enable_main_q[swd_pkg::BIT_TIMER1];
	for (genvar i = 0; i < 7; i++) begin : g_ext
		assign ext_irq[i] = ext_irq_req[i] && global_en && ext_en[i];
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_global_block: assert property (
		(wr_irq_enable_main && !wr_data[swd_pkg::BIT_GLOBAL]) |=>
		!serial0_irq && !timer0_ovf_irq && !timer1_ovf_irq && ext_irq == 7'h00)
		else $error("request passed with global enable low");
	chk_serial_gate: assert property (
		(wr_irq_enable_main && !wr_data[swd_pkg::BIT_SERIAL0]) |=> !serial0_irq)
		else $error("serial 0 request passed while disabled");
	chk_timer_gate: assert property (
		(wr_irq_enable_main && wr_data[3] == 1'b0 && wr_data[1] == 1'b0) |=>
		!timer1_ovf_irq && !timer0_ovf_irq)
		else $error("timer request passed while disabled");
	chk_ext_low_gate: assert property (
		(wr_irq_enable_main && wr_data[2] == 1'b0 && wr_data[0] == 1'b0) |=> ext_irq[1:0] == 2'h0)
		else $error("external 0 or 1 passed while disabled");
	chk_ext_high_gate: assert property (
		(wr_irq_enable_extended && wr_data[5:1] == 5'h00) |=> ext_irq[6:2] == 5'h00)
		else $error("external 2 to 6 passed while disabled");
	chk_arm_clear: assert property (
		(arm_q && age_q[0] == 4'hB && !arm_set) |=> !arm_q)
		else $error("arm flag outlived 12 cycles");
	chk_start_clear: assert property (
		(start_q && age_q[1] == 4'hB && !start_set) |=> !start_q)
		else $error("start flag outlived 12 cycles");
	chk_refresh_load: assert property (
		(start_set && arm_q && !expire) |=>
		cnt_q == {1'b0, $past(reload_q[6:0]), 8'h00} && running_q && !arm_q)
		else $error("refresh did not load the reload value");
	chk_expiry_reset: assert property (
		(running_q && cnt_q == 16'h7CFF) |=> wd_reset_req && status_q && !running_q)
		else $error("expiry did not raise reset and status");
	chk_status_keep: assert property (
		wd_reset_req |=> status_q || $past(wr_ip0))
		else $error("status flag lost across watchdog reset");
	chk_no_stop: assert property (
		(running_q && !expire) |=> running_q)
		else $error("running watchdog stopped without reset");
endmodule

// file: tb/sw_watchdog_irq_enables_tb.sv
// Self-checking bench for the software watchdog and interrupt enables
`timescale 1ns/1ps
module sw_watchdog_irq_enables_tb;
	localparam int BDIV = 4;
	localparam int XDIV = 2;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [swd_pkg::ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic serial_req = 1'b0, t0_req = 1'b0, t1_req = 1'b0;
	logic [6:0] ext_req = 7'h00;
	logic serial_irq, t0_irq, t1_irq, wd_running, wd_reset_req;
	logic [6:0] ext_out;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int t0 = 0;
	int seed = 32'h2d76;

	always #2 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	swd_top #(.BASE_DIV(BDIV), .EXTRA_DIV(XDIV), .FLAG_CYCLES(12)) dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial0_irq_req(serial_req), .timer0_ovf_req(t0_req),
		.timer1_ovf_req(t1_req), .ext_irq_req(ext_req), .serial0_irq(serial_irq),
		.timer0_ovf_irq(t0_irq), .timer1_ovf_irq(t1_irq), .ext_irq(ext_out),
		.wd_running(wd_running), .wd_reset_req(wd_reset_req));

	swd_cpu_model cpu (
		.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rvalid(rvalid), .rready(rready));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Results are noted when issued, compared while the answer stands
	// Falling edge: registered valids and data have settled, and the handshake
	// rising edge that ends the answer has not come yet
	always @(negedge aclk) begin
		if (rvalid && rready) begin
			if (rq.size() == 0)
				check({rresp, rdata}, 34'h3FFFFFFFF, "unexpected read");
			else
				check({rresp, rdata}, rq.pop_front(), "read");
		end
		if (bvalid && bready) begin
			if (bq.size() == 0)
				check({32'h0, bresp}, 34'h3FFFFFFFF, "unexpected write");
			else
				check({32'h0, bresp}, {32'h0, bq.pop_front()}, "write resp");
		end
	end

	task automatic wr(input logic [swd_pkg::ADDR_W-1:0] a, input logic [7:0] d,
		input logic [1:0] resp);
		bq.push_back(resp);
		cpu.wr(a, d);
	endtask

	task automatic rd(input logic [swd_pkg::ADDR_W-1:0] a, input logic [7:0] d,
		input logic [1:0] resp);
		rq.push_back({resp, 24'h000000, d});
		cpu.rd(a);
	endtask

	task automatic refresh();
		wr(swd_pkg::ADDR_IRQ_ENABLE_MAIN, 8'h40, swd_pkg::RESP_OKAY);
		wr(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h40, swd_pkg::RESP_OKAY);
		t0 = cyc;
	endtask

	// Span is counted from the refresh; edge alignment allows a few cycles slack
	task automatic expect_expiry(input int span);
		int n;
		n = 0;
		while (wd_reset_req !== 1'b1 && n < 5000) begin
			@(posedge aclk);
			#1;
			n++;
		end
		check({33'h0, (cyc - t0 >= span - 3) && (cyc - t0 <= span + 3)}, 34'h1, "expiry");
		@(posedge aclk);
		#1;
		check({32'h0, wd_reset_req, wd_running}, 34'h0, "after expiry");
		rd(swd_pkg::ADDR_IP0, 8'h40, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_RELOAD, 8'h00, swd_pkg::RESP_OKAY);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] e0, e1;
		logic [9:0] r;
		logic g;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		check({33'h0, wd_running}, 34'h0, "idle after reset");
		rd(swd_pkg::ADDR_RELOAD, 8'h00, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_IRQ_ENABLE_MAIN, 8'h00, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_IP0, 8'h00, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h00, swd_pkg::RESP_OKAY);
		rd(10'h3FC, 8'h00, swd_pkg::RESP_DECERR);
		wr(10'h3FC, 8'hFF, swd_pkg::RESP_DECERR);
		$display("test reset_values done");

		for (int i = 0; i < 20; i++) begin
			e0 = (i == 0) ? 8'h1F : 8'($random(seed)) & 8'h9F;
			e1 = (i == 0) ? 8'h3E : 8'($random(seed)) & 8'h3E;
			r = (i == 0) ? 10'h3FF : 10'($random(seed));
			wr(swd_pkg::ADDR_IRQ_ENABLE_MAIN, e0, swd_pkg::RESP_OKAY);
			wr(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, e1, swd_pkg::RESP_OKAY);
			rd(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, e1, swd_pkg::RESP_OKAY);
			serial_req <= r[9];
			t1_req <= r[8];
			t0_req <= r[7];
			ext_req <= r[6:0];
			@(posedge aclk);
			#1;
			g = e0[7];
			check({24'h0, serial_irq, t1_irq, t0_irq, ext_out},
				{24'h0, r[9] & g & e0[4], r[8] & g & e0[3], r[7] & g & e0[1],
				r[6:0] & {7{g}} & {e1[5:1], e0[2], e0[0]}},
				"irq gating");
		end
		$display("test irq_gating done");

		wr(swd_pkg::ADDR_IRQ_ENABLE_MAIN, 8'h00, swd_pkg::RESP_OKAY);
		wr(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h00, swd_pkg::RESP_OKAY);
		wr(swd_pkg::ADDR_IP0, 8'h15, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_IP0, 8'h15, swd_pkg::RESP_OKAY);
		wr(swd_pkg::ADDR_IRQ_ENABLE_MAIN, 8'h40, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_IRQ_ENABLE_MAIN, 8'h40, swd_pkg::RESP_OKAY);
		repeat (14) @(posedge aclk);
		rd(swd_pkg::ADDR_IRQ_ENABLE_MAIN, 8'h00, swd_pkg::RESP_OKAY);
		wr(swd_pkg::ADDR_RELOAD, 8'h7C, swd_pkg::RESP_OKAY);
		wr(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h40, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h40, swd_pkg::RESP_OKAY);
		check({33'h0, wd_running}, 34'h1, "started");
		repeat (14) @(posedge aclk);
		rd(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h00, swd_pkg::RESP_OKAY);
		refresh();
		expect_expiry(BDIV * 255);
		$display("test start_and_expire done");

		// A start without a fresh arm must not reload the counter
		wr(swd_pkg::ADDR_RELOAD, 8'h7C, swd_pkg::RESP_OKAY);
		refresh();
		repeat (300) @(posedge aclk);
		wr(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h40, swd_pkg::RESP_OKAY);
		expect_expiry(BDIV * 255);
		wr(swd_pkg::ADDR_IP0, 8'h40, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_IP0, 8'h40, swd_pkg::RESP_OKAY);
		wr(swd_pkg::ADDR_IP0, 8'h00, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_IP0, 8'h00, swd_pkg::RESP_OKAY);
		$display("test no_arm_no_reload done");

		wr(swd_pkg::ADDR_RELOAD, 8'hFC, swd_pkg::RESP_OKAY);
		rd(swd_pkg::ADDR_RELOAD, 8'hFC, swd_pkg::RESP_OKAY);
		refresh();
		repeat (300) @(posedge aclk);
		refresh();
		expect_expiry(BDIV * XDIV * 255);
		$display("test prescaled_rerefresh done");

		wr(swd_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h40, swd_pkg::RESP_OKAY);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		check({33'h0, wd_running}, 34'h0, "stopped by reset");
		rd(swd_pkg::ADDR_IP0, 8'h00, swd_pkg::RESP_OKAY);
		$display("test mid_run_reset done");
		print_verdict();
	end

	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		$display("MISMATCH t=%0t watchdog limit reached", $time);
		print_verdict();
	end
endmodule

// file: tb/swd_cpu_model.sv
// Processor-side register master driving the watchdog block over AXI4-Lite
`timescale 1ns/1ps
module swd_cpu_model (
	input wire logic aclk,
	output logic [swd_pkg::ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	output logic [swd_pkg::ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = '0;
		awvalid = 1'b0;
		wdata = 32'h00000000;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Address and data offered together, each dropped at its own handshake
	task automatic wr(input logic [swd_pkg::ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [swd_pkg::ADDR_W-1:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask
endmodule
